// *** hdl/boot_eprom_pkg.sv ***
// Constants shared by the boot EPROM window decode block
package boot_eprom_pkg;
    localparam int SW_W = 10;
    // Switch bank bit positions (position n sits at bit n-1)
    localparam int SW_A14 = 0;
    localparam int SW_A13 = 1;
    localparam int SW_A12 = 2;
    localparam int SW_A11 = 3;
    localparam int SW_SIZE_MSB = 4;
    localparam int SW_A10 = 5;
    localparam int SW_SIZE_LSB = 6;
    localparam int SW_A9 = 7;
    localparam int SW_BOOT = 8;
    localparam int SW_READABLE = 9;
    localparam int EPROM_AW = 15;
    localparam int BUS_AW = 16;
    localparam int IO_AW = 8;
    localparam logic [7:0] IO_BASE_RST = 8'hC0;
    localparam logic [1:0] REL_PORT_STATUS = 2'h2;
    localparam int READABLE_BIT = 2;
    localparam logic [2:0] WAIT_DEFAULT = 3'h3;
    localparam logic [2:0] WAIT_LONG = 3'h4;
    localparam logic [BUS_AW-1:0] BOOT_BASE_RST = 16'h0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } cyc_state_t;
endpackage

// *** hdl/boot_rom.sv ***
`timescale 1ns/10ps
`default_nettype none
// Boot EPROM array with registered read data
module boot_rom #(
    parameter int AW = 15,
    parameter int DW = 8
) (
    input wire logic sys_clk,
    input wire logic [AW-1:0] addr,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Load port stands in for device programming
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule
`default_nettype wire

// *** hdl/boot_eprom_window_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Switch OFF reads as one, ON reads as zero for each address bit.
// - Positions 1,2,3,4,6,8 drive EPROM A14,A13,A12,A11,A10,A9 where those bits lie above the block size.
// - Host sees one EPROM block of 512, 1K or 2K bytes.
// - Size from positions 5 (MSB) and 7 (LSB); OFF/OFF 512, 7 ON 1K, both 2K.
// - EPROMs of 8K to 32K; routine count is capacity over block size.
// - Boot enabled after reset only when position 9 is ON.
// - With boot enabled, reset fetches are answered from the selected block.
// - Bit 2 of relative I/O port 2 reads 0 if position 10 ON, else 1.
// - PHANTOM* is asserted while the host reads the boot EPROM.
// - Three wait states on EPROM reads by default, four when configured.
module boot_eprom_window_decode #(
    parameter int CAP_AW = 15,
    parameter logic [15:0] BOOT_BASE = boot_eprom_pkg::BOOT_BASE_RST,
    parameter logic [7:0] IO_BASE = boot_eprom_pkg::IO_BASE_RST
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [boot_eprom_pkg::SW_W-1:0] boot_config_switch_bank,
    input wire logic long_wait,
    input wire logic boot_disable,
    input wire logic [boot_eprom_pkg::BUS_AW-1:0] bus_addr,
    input wire logic bus_memr,
    input wire logic bus_inp,
    input wire logic bus_sync,
    input wire logic rom_wr_en,
    input wire logic [boot_eprom_pkg::EPROM_AW-1:0] rom_wr_addr,
    input wire logic [7:0] rom_wr_data,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    output logic phantom_n,
    output logic rdy,
    output logic boot_active,
    output logic [boot_eprom_pkg::EPROM_AW-1:0] eprom_addr
);
    typedef struct packed {
        logic [boot_eprom_pkg::SW_W-1:0] sw_s1;
        logic [boot_eprom_pkg::SW_W-1:0] sw_s2;
        logic lw_s1;
        logic lw_s2;
        logic boot_en;
        boot_eprom_pkg::cyc_state_t st;
        logic [2:0] wait_cnt;
        logic mem_cyc;
        logic io_cyc;
        logic [boot_eprom_pkg::BUS_AW-1:0] addr;
        logic [7:0] io_data;
        logic phantom;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [7:0] rom_q;
    logic [boot_eprom_pkg::EPROM_AW-1:0] rom_addr;

    // Block offset mask from size code: 512 -> 9 bits, 1K -> 10, 2K -> 11
    function automatic logic [10:0] size_mask(input logic [1:0] code);
        case (code)
            2'h1: size_mask = 11'h3FF;
            2'h3: size_mask = 11'h7FF;
            default: size_mask = 11'h1FF;
        endcase
    endfunction

    logic [1:0] size_code;
    logic [10:0] off_mask;
    logic [5:0] blk_bits;
    logic in_window;
    logic io_hit;
    logic [1:0] rel_cnt_q;
    logic rst_n_seen_q;

    always_comb begin
        // Closed switch pulls low, so active-high sense is the inverted level
        size_code = {~s_q.sw_s2[boot_eprom_pkg::SW_SIZE_MSB],
                     ~s_q.sw_s2[boot_eprom_pkg::SW_SIZE_LSB]};
        off_mask = size_mask(size_code);
        blk_bits = {s_q.sw_s2[boot_eprom_pkg::SW_A14], s_q.sw_s2[boot_eprom_pkg::SW_A13],
                    s_q.sw_s2[boot_eprom_pkg::SW_A12], s_q.sw_s2[boot_eprom_pkg::SW_A11],
                    s_q.sw_s2[boot_eprom_pkg::SW_A10], s_q.sw_s2[boot_eprom_pkg::SW_A9]};
        // In-block bits come from the bus; installer leaves those switches OFF
        rom_addr = {blk_bits, 9'h000};
        rom_addr[10:0] = ({blk_bits[1:0], 9'h000} & ~off_mask) | (bus_addr[10:0] & off_mask);
        // Above fitted capacity the address lines are unused
        if (CAP_AW < boot_eprom_pkg::EPROM_AW) begin
            rom_addr = rom_addr & ((15'h7FFF) >> (boot_eprom_pkg::EPROM_AW - CAP_AW));
        end
        in_window = s_q.boot_en &&
                    ((bus_addr & ~{5'h00, off_mask}) == (BOOT_BASE & ~{5'h00, off_mask}));
        io_hit = (bus_addr[7:2] == IO_BASE[7:2]) &&
                 (bus_addr[1:0] == boot_eprom_pkg::REL_PORT_STATUS);
    end

    always_comb begin
        s_d = s_q;
        s_d.sw_s1 = boot_config_switch_bank;
        s_d.sw_s2 = s_q.sw_s1;
        s_d.lw_s1 = long_wait;
        s_d.lw_s2 = s_q.lw_s1;
        if (boot_disable) begin
            s_d.boot_en = 1'b0;
        end
        case (s_q.st)
            boot_eprom_pkg::ST_IDLE: begin
                s_d.phantom = 1'b0;
                s_d.mem_cyc = 1'b0;
                s_d.io_cyc = 1'b0;
                if (bus_sync && bus_memr && in_window) begin
                    s_d.st = boot_eprom_pkg::ST_WAIT;
                    s_d.mem_cyc = 1'b1;
                    s_d.phantom = 1'b1;
                    s_d.addr = bus_addr;
                    s_d.wait_cnt = s_q.lw_s2 ? boot_eprom_pkg::WAIT_LONG
                                             : boot_eprom_pkg::WAIT_DEFAULT;
                end else if (bus_sync && bus_inp && io_hit) begin
                    s_d.st = boot_eprom_pkg::ST_DONE;
                    s_d.io_cyc = 1'b1;
                    s_d.io_data = 8'h00;
                    s_d.io_data[boot_eprom_pkg::READABLE_BIT] =
                        s_q.sw_s2[boot_eprom_pkg::SW_READABLE];
                end
            end
            boot_eprom_pkg::ST_WAIT: begin
                s_d.wait_cnt = s_q.wait_cnt - 3'h1;
                if (s_q.wait_cnt == 3'h1) begin
                    s_d.st = boot_eprom_pkg::ST_DONE;
                end
            end
            boot_eprom_pkg::ST_DONE: begin
                if (!bus_memr && !bus_inp) begin
                    s_d.st = boot_eprom_pkg::ST_IDLE;
                    s_d.phantom = 1'b0;
                    s_d.mem_cyc = 1'b0;
                    s_d.io_cyc = 1'b0;
                end
            end
            default: s_d.st = boot_eprom_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= boot_eprom_pkg::ST_IDLE;
            // Switch samples rest at all-OFF until the synchroniser fills
            s_q.sw_s1 <= 10'h3FF;
            s_q.sw_s2 <= 10'h3FF;
            s_q.boot_en <= 1'b0;
        end else begin
            s_q <= s_d;
            // Boot latch follows position 9 at each of the first four edges after release; the fourth is kept
            if (!rst_n_seen_q) begin
                s_q.boot_en <= ~s_q.sw_s2[boot_eprom_pkg::SW_BOOT] & ~boot_disable;
            end
        end
    end

    // Waits four edges after release so the switch synchroniser is full
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rel_cnt_q <= 2'h0;
            rst_n_seen_q <= 1'b0;
        end else begin
            if (rel_cnt_q != 2'h3) begin
                rel_cnt_q <= rel_cnt_q + 2'h1;
            end
            rst_n_seen_q <= (rel_cnt_q == 2'h3);
        end
    end

    boot_rom #(
        .AW(boot_eprom_pkg::EPROM_AW),
        .DW(8)
    ) u_rom (
        .sys_clk(sys_clk),
        .addr(rom_addr),
        .wr_en(rom_wr_en),
        .wr_addr(rom_wr_addr),
        .wr_data(rom_wr_data),
        .rd_data(rom_q)
    );

    logic [7:0] data_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            data_q <= 8'h00;
        end else if (s_q.st == boot_eprom_pkg::ST_WAIT) begin
            data_q <= rom_q;
        end else if (s_d.io_cyc && !s_q.io_cyc) begin
            data_q <= s_d.io_data;
        end
    end

    assign bus_data_out = data_q;
    assign bus_data_oe = (s_q.st == boot_eprom_pkg::ST_DONE) &&
                         ((s_q.mem_cyc && bus_memr) || (s_q.io_cyc && bus_inp));
    assign phantom_n = ~s_q.phantom;
    assign rdy = ~(s_q.st == boot_eprom_pkg::ST_WAIT);
    assign boot_active = s_q.boot_en;
    assign eprom_addr = rom_addr;
endmodule
`default_nettype wire

// *** verification/boot_eprom_window_decode_sva.sv ***
// Port assertions for the boot window decode
`timescale 1ns/10ps
`default_nettype none
module boot_eprom_window_decode_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [9:0] boot_config_switch_bank,
    input wire logic long_wait,
    input wire logic [15:0] bus_addr,
    input wire logic bus_memr,
    input wire logic bus_inp,
    input wire logic bus_sync,
    input wire logic [7:0] bus_data_out,
    input wire logic bus_data_oe,
    input wire logic phantom_n,
    input wire logic rdy,
    input wire logic boot_active,
    input wire logic [14:0] eprom_addr
);
    wire [9:0] s = boot_config_switch_bank;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_idle; !bus_memr && !bus_inp |=> !bus_data_oe; endproperty
    a_idle: assert property (p_idle) else $error("oe without strobe");
    property p_ph; bus_data_oe && bus_memr |-> !phantom_n; endproperty
    a_ph: assert property (p_ph) else $error("phantom_n high on read");
    property p_w3; $fell(phantom_n) && !long_wait |-> !rdy [*3] ##1 rdy; endproperty
    a_w3: assert property (p_w3) else $error("short wait count");
    property p_w4; $fell(phantom_n) && long_wait |-> !rdy [*4] ##1 rdy; endproperty
    a_w4: assert property (p_w4) else $error("long wait count");
    property p_cause;
        $fell(phantom_n) |-> $past(bus_sync) && $past(bus_memr) && $past(boot_active);
    endproperty
    a_cause: assert property (p_cause) else $error("read without boot");
    property p_io;
        bus_sync && bus_inp && bus_addr[7:0] == 8'hC2 |=>
            bus_data_oe && bus_data_out == {5'h00, s[9], 2'h0};
    endproperty
    a_io: assert property (p_io) else $error("status bit wrong");
    property p_hi; !phantom_n |-> eprom_addr[14:11] == {s[0], s[1], s[2], s[3]}; endproperty
    a_hi: assert property (p_hi) else $error("upper address wrong");
    property p_sz;
        !phantom_n |-> eprom_addr[8:0] == bus_addr[8:0] && eprom_addr[10:9] ==
            {s[4] ? s[5] : bus_addr[10], s[4] && s[6] ? s[7] : bus_addr[9]};
    endproperty
    a_sz: assert property (p_sz) else $error("block size decode wrong");
    c_io: cover property (bus_sync && bus_inp);
    c_long: cover property ($fell(phantom_n) && long_wait);
    c_2k: cover property ($fell(phantom_n) && !s[4]);
endmodule
bind boot_eprom_window_decode boot_eprom_window_decode_sva chk (.sys_clk, .rst_n,
    .boot_config_switch_bank, .long_wait, .bus_addr, .bus_memr, .bus_inp, .bus_sync,
    .bus_data_out, .bus_data_oe, .phantom_n, .rdy, .boot_active, .eprom_addr);
`default_nettype wire

// *** verification/host_bus_model.sv ***
// Host processor model issuing memory and I/O read cycles
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    input wire logic sys_clk,
    input wire logic [7:0] bus_data_out,
    input wire logic bus_data_oe,
    input wire logic phantom_n,
    output logic [15:0] bus_addr,
    output logic bus_memr,
    output logic bus_inp,
    output logic bus_sync
);
    logic mem_oe;
    // Low RAM yields whenever the boot window claims the cycle
    assign mem_oe = bus_memr && phantom_n && bus_addr < 16'h0800;
    initial begin
        bus_addr = 16'hFFFF;
        bus_memr = 1'b0;
        bus_inp = 1'b0;
        bus_sync = 1'b0;
    end
    task automatic rd(input logic io, input logic [15:0] a, output logic [7:0] d,
        output logic ok);
        int n;
        @(posedge sys_clk);
        #1 bus_addr = a;
        bus_memr = !io;
        bus_inp = io;
        bus_sync = 1'b1;
        @(posedge sys_clk);
        #1 bus_sync = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        // Sampled mid-cycle, away from the edge that launches the answer
        for (n = 0; n < 10 && ok !== 1'b1; n++) begin
            @(negedge sys_clk);
            ok = bus_data_oe;
            d = bus_data_out;
        end
        // Both sides driving the bus is reported as an unknown answer
        if (mem_oe && bus_data_oe) ok = 1'bx;
        @(posedge sys_clk);
        #1 bus_memr = 1'b0;
        bus_inp = 1'b0;
        // Released lines must not keep the old address
        bus_addr = ~a;
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// *** verification/boot_eprom_window_decode_bench.sv ***
// Self-checking bench for the boot window decode
`timescale 1ns/10ps
`default_nettype none
module boot_eprom_window_decode_bench;
    logic sys_clk, rst_n, long_wait, boot_disable, rom_wr_en, oe, phantom_n, act, ok;
    logic bus_memr, bus_inp, bus_sync;
    logic [9:0] sw;
    logic [14:0] rom_wr_addr;
    logic [15:0] bus_addr;
    logic [7:0] rom_wr_data, dout, d;
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 60;
    boot_eprom_window_decode dut (.sys_clk, .rst_n, .boot_config_switch_bank(sw),
        .long_wait, .boot_disable, .bus_addr, .bus_memr, .bus_inp, .bus_sync, .rom_wr_en,
        .rom_wr_addr, .rom_wr_data, .bus_data_out(dout), .bus_data_oe(oe), .phantom_n,
        .rdy(), .boot_active(act), .eprom_addr());
    host_bus_model host (.sys_clk, .bus_data_out(dout), .bus_data_oe(oe), .phantom_n,
        .bus_addr, .bus_memr, .bus_inp, .bus_sync);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    function automatic logic [14:0] exp_addr(input logic [9:0] s, input logic [15:0] a);
        logic [14:0] e;
        e = {s[0], s[1], s[2], s[3], s[5], s[7], a[8:0]};
        if (!s[6]) e[9] = a[9];
        if (!s[4]) e[10:9] = a[10:9];
        return e;
    endfunction
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, input logic g);
        chk_byte(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic on);
        @(posedge sys_clk);
        #1 rst_n = 1'b0;
        sw[8] = !on;
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 chk_flag("boot_active", on, act);
    endtask
    task automatic trial(input logic on, input logic [9:0] s);
        logic [15:0] a, sz;
        logic [7:0] v;
        #1;
        s[8] = !on;
        if (!s[4]) s[6] = 1'b0;
        if (!s[4]) s[5] = 1'b1;
        if (!s[6]) s[7] = 1'b1;
        sw = s;
        long_wait = 1'($random(seed));
        sz = s[4] ? (s[6] ? 16'h0200 : 16'h0400) : 16'h0800;
        a = 16'($random(seed)) & (sz - 16'h0001);
        v = 8'($random(seed));
        rom_wr_addr = exp_addr(s, a);
        rom_wr_data = v;
        rom_wr_en = 1'b1;
        @(posedge sys_clk);
        #1 rom_wr_en = 1'b0;
        repeat (4) @(posedge sys_clk);
        host.rd(1'b0, a, d, ok);
        chk_flag("mem answer", on, ok);
        if (on) chk_byte("mem data", v, d);
        host.rd(1'b0, sz, d, ok);
        chk_flag("outside answer", 1'b0, ok);
        host.rd(1'b1, 16'h00C2, d, ok);
        chk_byte("status port", {5'h00, s[9], 2'h0}, d);
    endtask
    initial begin
        {rst_n, long_wait, boot_disable, rom_wr_en} = 4'h0;
        sw = 10'h3FF;
        rom_wr_addr = 15'h0000;
        rom_wr_data = 8'h00;
        do_reset(1'b1);
        trial(1'b1, 10'h000);
        trial(1'b1, 10'h3FF);
        repeat (24) trial(1'b1, 10'($random(seed)));
        @(posedge sys_clk);
        #1 boot_disable = 1'b1;
        @(posedge sys_clk);
        #1 boot_disable = 1'b0;
        trial(1'b0, 10'h2BF);
        $display("test boot on done");
        do_reset(1'b0);
        repeat (6) trial(1'b0, 10'($random(seed)));
        $display("test boot off done");
        give_verdict();
    end
    initial begin
        #60000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
